// ### asc_top.sv
// Contract
// - Converter clock is peripheral clock divided by 2 to 256 per 3-bit code.
// - Startup wait of 0..256 converter cycles before first sample after enable or internal ref.
// - Startup wait also applies on deep-sleep wake for a measurement.
// - With auto variation on, inter-sample wait increments after every sample.
// - Auto-incremented inter-sample wait wraps from 0xF to 0x0.
// - Wait inter-sample wait converter cycles between consecutive samples.
// - Sampling switch stays open during the inter-sample wait.
// - Window flag follows mode: never, below, above, inside, outside.
// - Window compares full 16-bit result against 16-bit thresholds.
// - Sampling lasts two converter cycles plus the 5-bit extension.
// - Five-bit channel code selects pins, DAC, reference, temperature or ground.
// - Channel change during a conversion applies only after it completes.
// - Writing one to start bit begins one measurement or free-running sequence.
// - Start bit reads one while busy and clears itself on completion.
// - Writing zero to start bit during a conversion aborts it.
// - With event start enabled, an incoming event starts a conversion.
// - Enable and flag bits: window at bit 1, result at bit 0.
// - Window flag set at conversion end on match; cleared by one or result read.
// - Result flag set on completion; cleared by writing one or result read.
module asc_top
  import asc_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [7:0]  s_awaddr,
  // axi4-lite write data
  input  wire logic        s_wvalid,
  output logic             s_wready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  // axi4-lite write response
  output logic             s_bvalid,
  input  wire logic        s_bready,
  output logic [1:0]       s_bresp,
  // axi4-lite read address
  input  wire logic        s_arvalid,
  output logic             s_arready,
  input  wire logic [7:0]  s_araddr,
  // axi4-lite read data
  output logic             s_rvalid,
  input  wire logic        s_rready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  // system events
  input  wire logic        start_event,
  input  wire logic        wake_measure,
  // analog core
  input  wire logic [9:0]  sample_data,
  output logic             conv_clk,
  output logic             sample_switch,
  output logic [4:0]       chan_sel,
  output logic             irq
);

  // ****************************************
  // registers
  // ****************************************
  logic [1:0]  ctrl_a_q;
  asc_ctrl_c_t ctrl_c_q;
  asc_dly_t    dly_q;
  logic [2:0]  win_mode_q;
  logic [4:0]  samp_ext_q;
  logic [4:0]  chan_code_q;
  logic        evt_en_q;
  logic [1:0]  irq_en_q;
  logic [1:0]  flags_q, flags_d;
  logic [15:0] result_q, win_lo_q, win_hi_q;
  asc_state_t  state_q, state_d;
  logic [8:0]  cnt_q, cnt_d, target;
  logic        init_pend_q;
  logic        aw_full_q, w_full_q, awready_q, wready_q, bvalid_q;
  logic        arready_q, rvalid_q;
  logic [5:0]  wr_idx_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0]  wstrb_q;
  logic [1:0]  bresp_q, rresp_q;
  logic        switch_q, irq_q;
  logic [4:0]  chan_sel_q;

  // ****************************************
  // bus handshake
  // ****************************************
  logic aw_take, w_take, ar_take, do_wr, aw_full_d, w_full_d, bvalid_d, rvalid_d;
  logic [5:0]  rd_idx;
  logic        rd_hit, wr_hit;
  logic [31:0] rd_word;

  assign aw_take   = s_awvalid && awready_q;
  assign w_take    = s_wvalid && wready_q;
  assign ar_take   = s_arvalid && arready_q;
  assign do_wr     = aw_full_q && w_full_q && !bvalid_q;
  assign aw_full_d = (aw_full_q || aw_take) && !do_wr;
  assign w_full_d  = (w_full_q || w_take) && !do_wr;
  assign bvalid_d  = do_wr || (bvalid_q && !s_bready);
  assign rvalid_d  = ar_take || (rvalid_q && !s_rready);
  assign rd_idx    = s_araddr[7:2];

  function automatic logic mapped(input logic [5:0] idx);
    mapped = (idx inside {IDX_CTRL_A, IDX_CTRL_C, IDX_DLY, IDX_WIN_MODE, IDX_SAMP_LEN,
                          IDX_CHAN, IDX_CMD, IDX_EVT, IDX_IRQ_EN, IDX_IRQ_FLAG,
                          IDX_RESULT, IDX_WIN_LO, IDX_WIN_HI});
  endfunction

  assign rd_hit = mapped(rd_idx);
  assign wr_hit = mapped(wr_idx_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      wr_idx_q  <= 6'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      bresp_q   <= RESP_OKAY;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= RESP_OKAY;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q  <= w_full_d;
      awready_q <= !aw_full_d && !bvalid_d;
      wready_q  <= !w_full_d && !bvalid_d;
      bvalid_q  <= bvalid_d;
      arready_q <= !rvalid_d;
      rvalid_q  <= rvalid_d;
      if (aw_take) begin
        wr_idx_q <= s_awaddr[7:2];
      end
      if (w_take) begin
        wdata_q <= s_wdata;
        wstrb_q <= s_wstrb;
      end
      if (do_wr) begin
        bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (ar_take) begin
        rdata_q <= rd_word;
        rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // ****************************************
  // register writes
  // ****************************************
  logic wr_lo, wr_hi, wr_cmd, start_req, stop_req, evt_start, res_rd, go, busy;
  logic enable_rise, ref_to_int, flag_clr_res, flag_clr_win;

  assign wr_lo       = do_wr && wstrb_q[0];
  assign wr_hi       = do_wr && wstrb_q[1];
  assign wr_cmd      = wr_lo && (wr_idx_q == IDX_CMD);
  assign start_req   = wr_cmd && wdata_q[BIT_START];
  assign stop_req    = wr_cmd && !wdata_q[BIT_START];
  assign busy        = (state_q != ST_IDLE);
  assign evt_start   = start_event && evt_en_q;
  // start on command, event or wake
  assign go          = (start_req || evt_start || wake_measure) && ctrl_a_q[BIT_ENABLE] && !busy;
  assign res_rd      = ar_take && (rd_idx == IDX_RESULT);
  assign enable_rise = wr_lo && (wr_idx_q == IDX_CTRL_A) && wdata_q[BIT_ENABLE] && !ctrl_a_q[BIT_ENABLE];
  assign ref_to_int  = wr_lo && (wr_idx_q == IDX_CTRL_C) && (wdata_q[5:4] == REF_INTERNAL)
                       && (ctrl_c_q.refsel != REF_INTERNAL);

  // ****************************************
  // sequencer
  // ****************************************
  logic tick, tick_end, conv_done, sample_done, win_match;

  asc_clkdiv u_clkdiv (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .clock_divider_code    (ctrl_c_q.clock_divider_code),
    .tick     (tick),
    .conv_clk (conv_clk)
  );

  always_comb begin
    case (state_q)
      ST_INIT:    target = init_cycles(dly_q.init_code);
      ST_SAMPLE:  target = SAMPLE_BASE + {4'h0, samp_ext_q};
      ST_CONVERT: target = CONV_TICKS;
      ST_GAP:     target = {5'h00, dly_q.gap};
      default:    target = 9'h000;
    endcase
  end

  assign tick_end    = tick && (cnt_q == target - 9'h001);
  assign sample_done = (state_q == ST_SAMPLE) && tick_end;
  assign conv_done   = (state_q == ST_CONVERT) && tick_end;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        // wake also runs pending startup wait
        if (go) begin
          state_d = ((init_pend_q || wake_measure) && init_cycles(dly_q.init_code) != 9'h000) ? ST_INIT : ST_SAMPLE;
        end
      end
      ST_INIT: begin
        if (tick_end) begin
          state_d = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        if (tick_end) begin
          state_d = ST_CONVERT;
        end
      end
      ST_CONVERT: begin
        if (tick_end) begin
          state_d = !ctrl_a_q[BIT_FREERUN] ? ST_IDLE : (dly_q.gap != 4'h0) ? ST_GAP : ST_SAMPLE;
        end
      end
      ST_GAP: begin
        if (tick_end) begin
          state_d = ST_SAMPLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
    if (stop_req || !ctrl_a_q[BIT_ENABLE]) begin
      state_d = ST_IDLE;
    end
  end

  assign cnt_d = (state_d != state_q) ? 9'h000 : tick ? cnt_q + 9'h001 : cnt_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q     <= ST_IDLE;
      cnt_q       <= 9'h000;
      init_pend_q <= 1'b0;
    end else begin
      state_q     <= state_d;
      cnt_q       <= cnt_d;
      // arm startup wait on enable or internal reference
      init_pend_q <= enable_rise || ref_to_int || ((wake_measure || init_pend_q) && !go);
    end
  end

  // ****************************************
  // window compare and flags
  // ****************************************
  // full 16-bit result compared
  asc_window u_window (
    .value    ({6'h00, sample_data}),
    .low_thr  (win_lo_q),
    .high_thr (win_hi_q),
    .mode     (win_mode_q),
    .match    (win_match)
  );

  assign flag_clr_res = res_rd || (wr_lo && (wr_idx_q == IDX_IRQ_FLAG) && wdata_q[FLAG_RESULT]);
  assign flag_clr_win = res_rd || (wr_lo && (wr_idx_q == IDX_IRQ_FLAG) && wdata_q[FLAG_WINDOW]);

  // result flag, set wins over clear
  assign flags_d[FLAG_RESULT] = conv_done || (flags_q[FLAG_RESULT] && !flag_clr_res);
  assign flags_d[FLAG_WINDOW] = (conv_done && win_match) || (flags_q[FLAG_WINDOW] && !flag_clr_win);

  // ****************************************
  // control registers
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_a_q    <= 2'h0;
      ctrl_c_q    <= '0;
      dly_q       <= RESET_BYTE;
      win_mode_q  <= 3'h0;
      samp_ext_q  <= 5'h00;
      chan_code_q <= 5'h00;
      evt_en_q    <= 1'b0;
      irq_en_q    <= 2'h0;
      flags_q     <= 2'h0;
      result_q    <= 16'h0000;
      win_lo_q    <= 16'h0000;
      win_hi_q    <= 16'h0000;
    end else begin
      flags_q <= flags_d;
      if (conv_done) begin
        result_q <= {6'h00, sample_data};
      end
      if (sample_done && dly_q.auto_vary) begin
        dly_q.gap <= dly_q.gap + 4'h1;
      end
      if (wr_lo) begin
        case (wr_idx_q)
          IDX_CTRL_A:   ctrl_a_q    <= wdata_q[1:0];
          IDX_CTRL_C:   ctrl_c_q    <= {wdata_q[5:4], wdata_q[2:0]};
          IDX_DLY:      dly_q       <= wdata_q[7:0];
          IDX_WIN_MODE: win_mode_q  <= wdata_q[2:0];
          IDX_SAMP_LEN: samp_ext_q  <= wdata_q[4:0];
          IDX_CHAN:     chan_code_q <= wdata_q[4:0];
          IDX_EVT:      evt_en_q    <= wdata_q[BIT_EVT_EN];
          // enables at bits 1 and 0
          IDX_IRQ_EN:   irq_en_q    <= wdata_q[1:0];
          IDX_WIN_LO:   win_lo_q[7:0] <= wdata_q[7:0];
          IDX_WIN_HI:   win_hi_q[7:0] <= wdata_q[7:0];
          default:      ;
        endcase
      end
      if (wr_hi && wr_idx_q == IDX_WIN_LO) begin
        win_lo_q[15:8] <= wdata_q[15:8];
      end
      if (wr_hi && wr_idx_q == IDX_WIN_HI) begin
        win_hi_q[15:8] <= wdata_q[15:8];
      end
    end
  end

  // ****************************************
  // read mux
  // ****************************************
  // start bit reads busy
  assign rd_word = (rd_idx == IDX_CTRL_A)   ? {30'h0, ctrl_a_q} :
                   (rd_idx == IDX_CTRL_C)   ? {26'h0, ctrl_c_q.refsel, 1'b0, ctrl_c_q.clock_divider_code} :
                   (rd_idx == IDX_DLY)      ? {24'h0, dly_q} :
                   (rd_idx == IDX_WIN_MODE) ? {29'h0, win_mode_q} :
                   (rd_idx == IDX_SAMP_LEN) ? {27'h0, samp_ext_q} :
                   (rd_idx == IDX_CHAN)     ? {27'h0, chan_code_q} :
                   (rd_idx == IDX_CMD)      ? {31'h0, busy} :
                   (rd_idx == IDX_EVT)      ? {31'h0, evt_en_q} :
                   (rd_idx == IDX_IRQ_EN)   ? {30'h0, irq_en_q} :
                   (rd_idx == IDX_IRQ_FLAG) ? {30'h0, flags_q} :
                   (rd_idx == IDX_RESULT)   ? {16'h0, result_q} :
                   (rd_idx == IDX_WIN_LO)   ? {16'h0, win_lo_q} :
                   (rd_idx == IDX_WIN_HI)   ? {16'h0, win_hi_q} : 32'h0000_0000;

  // ****************************************
  // analog core drive and interrupt
  // ****************************************
  logic [1:0] irq_en_d;

  // enable as written this cycle, so irq tracks flags and enables together
  assign irq_en_d = (wr_lo && (wr_idx_q == IDX_IRQ_EN)) ? wdata_q[1:0] : irq_en_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      switch_q   <= 1'b0;
      chan_sel_q <= 5'h00;
      irq_q      <= 1'b0;
    end else begin
      switch_q <= (state_d == ST_SAMPLE);
      if (state_d == ST_SAMPLE && state_q != ST_SAMPLE) begin
        chan_sel_q <= route_chan(chan_code_q);
      end
      irq_q <= |(flags_d & irq_en_d);
    end
  end

  assign s_awready     = awready_q;
  assign s_wready      = wready_q;
  assign s_bvalid      = bvalid_q;
  assign s_bresp       = bresp_q;
  assign s_arready     = arready_q;
  assign s_rvalid      = rvalid_q;
  assign s_rdata       = rdata_q;
  assign s_rresp       = rresp_q;
  assign sample_switch = switch_q;
  assign chan_sel      = chan_sel_q;
  assign irq           = irq_q;

  // ****************************************
  // assertions
  // ****************************************
  // tick under divide-by-two, code held over the whole period
  sequence s_div0_tick;
    (tick && ctrl_c_q.clock_divider_code == 3'h0) ##1 (ctrl_c_q.clock_divider_code == 3'h0);
  endsequence
  a_div_by_two: assert property (@(posedge aclk) disable iff (!aresetn)
    s_div0_tick |=> tick)
    else $error("divider period wrong");
  a_gap_switch_open: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_q == ST_GAP) |-> !sample_switch)
    else $error("switch closed during gap");
  a_chan_held: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_q == ST_CONVERT) |-> $stable(chan_sel))
    else $error("channel changed mid conversion");
  a_gap_wraps: assert property (@(posedge aclk) disable iff (!aresetn)
    (sample_done && dly_q.auto_vary && dly_q.gap == 4'hF && !wr_lo) |=> (dly_q.gap == 4'h0))
    else $error("gap did not wrap");
  a_start_busy: assert property (@(posedge aclk) disable iff (!aresetn)
    (go && !stop_req) |=> busy)
    else $error("start not busy");
  a_abort_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    (stop_req && busy) |=> (state_q == ST_IDLE))
    else $error("abort ignored");
  a_result_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    conv_done |=> flags_q[FLAG_RESULT])
    else $error("result flag not set");
  a_irq_follows: assert property (@(posedge aclk) disable iff (!aresetn)
    (|(flags_q & irq_en_q)) |-> irq)
    else $error("irq missing");

endmodule

// ### asc_pkg.sv
package asc_pkg;

  // ****************************************
  // register indices (byte address = 4 * index)
  // ****************************************
  localparam logic [5:0] IDX_CTRL_A   = 6'h00;
  localparam logic [5:0] IDX_CTRL_C   = 6'h02;
  localparam logic [5:0] IDX_DLY      = 6'h03;
  localparam logic [5:0] IDX_WIN_MODE = 6'h04;
  localparam logic [5:0] IDX_SAMP_LEN = 6'h05;
  localparam logic [5:0] IDX_CHAN     = 6'h06;
  localparam logic [5:0] IDX_CMD      = 6'h08;
  localparam logic [5:0] IDX_EVT      = 6'h09;
  localparam logic [5:0] IDX_IRQ_EN   = 6'h0A;
  localparam logic [5:0] IDX_IRQ_FLAG = 6'h0B;
  localparam logic [5:0] IDX_RESULT   = 6'h10;
  localparam logic [5:0] IDX_WIN_LO   = 6'h12;
  localparam logic [5:0] IDX_WIN_HI   = 6'h14;

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int unsigned BIT_ENABLE   = 0;
  localparam int unsigned BIT_FREERUN  = 1;
  localparam int unsigned BIT_START    = 0;
  localparam int unsigned BIT_EVT_EN   = 0;
  localparam int unsigned FLAG_RESULT  = 0;
  localparam int unsigned FLAG_WINDOW  = 1;
  localparam logic [1:0]  REF_INTERNAL = 2'h0;
  localparam logic [7:0]  RESET_BYTE   = 8'h00;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // ****************************************
  // timing in converter clock cycles, and the ground channel code
  // ****************************************
  localparam logic [8:0] SAMPLE_BASE = 9'h002;
  localparam logic [8:0] CONV_TICKS  = 9'h00B;
  localparam logic [4:0] CHAN_GND    = 5'h1F;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    WIN_NONE    = 3'b000,
    WIN_BELOW   = 3'b001,
    WIN_ABOVE   = 3'b010,
    WIN_INSIDE  = 3'b011,
    WIN_OUTSIDE = 3'b100
  } asc_win_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_INIT    = 3'b001,
    ST_SAMPLE  = 3'b010,
    ST_CONVERT = 3'b011,
    ST_GAP     = 3'b100
  } asc_state_t;

  typedef struct packed {
    logic [2:0] init_code;
    logic       auto_vary;
    logic [3:0] gap;
  } asc_dly_t;

  typedef struct packed {
    logic [1:0] refsel;
    logic [2:0] clock_divider_code;
  } asc_ctrl_c_t;

  // startup delay length per code, reserved codes give none
  function automatic logic [8:0] init_cycles(input logic [2:0] code);
    case (code)
      3'h1:    init_cycles = 9'h010;
      3'h2:    init_cycles = 9'h020;
      3'h3:    init_cycles = 9'h040;
      3'h4:    init_cycles = 9'h080;
      3'h5:    init_cycles = 9'h100;
      default: init_cycles = 9'h000;
    endcase
  endfunction

  // reserved channel codes route to ground
  function automatic logic [4:0] route_chan(input logic [4:0] code);
    case (code)
      5'h00, 5'h01, 5'h02, 5'h03, 5'h06, 5'h07,
      5'h1C, 5'h1D, 5'h1E, 5'h1F: route_chan = code;
      default:                    route_chan = CHAN_GND;
    endcase
  endfunction

endpackage

// ### asc_clkdiv.sv
module asc_clkdiv
  import asc_pkg::*;
(
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // control
  input  wire logic [2:0] clock_divider_code,
  // converter clock
  output logic            tick,
  output logic            conv_clk
);

  logic [7:0] cnt_q;
  logic [7:0] mask;
  logic       tick_d;

  // divide by 2 at code 0 up to 256 at code 7
  assign mask   = 8'(9'h002 << clock_divider_code) - 8'h01;
  assign tick_d = &(cnt_q | ~mask);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q    <= 8'h00;
      tick     <= 1'b0;
      conv_clk <= 1'b0;
    end else begin
      cnt_q    <= tick_d ? 8'h00 : cnt_q + 8'h01;
      tick     <= tick_d;
      conv_clk <= ((cnt_q & mask) > (mask >> 1));
    end
  end

endmodule

// ### asc_window.sv
module asc_window
  import asc_pkg::*;
(
  // operands
  input  wire logic [15:0] value,
  input  wire logic [15:0] low_thr,
  input  wire logic [15:0] high_thr,
  input  wire logic [2:0]  mode,
  // result
  output logic             match
);

  logic below;
  logic above;

  assign below = value < low_thr;
  assign above = value > high_thr;

  always_comb begin
    case (asc_win_mode_t'(mode))
      WIN_BELOW:   match = below;
      WIN_ABOVE:   match = above;
      WIN_INSIDE:  match = (value > low_thr) && (value < high_thr);
      WIN_OUTSIDE: match = below || above;
      default:     match = 1'b0;
    endcase
  end

endmodule

// ### tb_asc_top.sv
module tb_asc_top
  import asc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct packed {
    logic [5:0]  idx;
    logic [31:0] wd;
    logic [31:0] ex;
    logic [1:0]  rs;
  } asc_tb_row_t;

  typedef struct packed {
    logic [2:0] m;
    logic [9:0] s;
    logic       e;
  } asc_tb_win_t;

  logic        aclk         = 1'b0;
  logic        aresetn      = 1'b0;
  logic        s_awvalid    = 1'b0;
  logic        s_wvalid     = 1'b0;
  logic        s_bready     = 1'b0;
  logic        s_arvalid    = 1'b0;
  logic        s_rready     = 1'b0;
  logic        start_event  = 1'b0;
  logic        wake_measure = 1'b0;
  logic [7:0]  s_awaddr     = 8'h00;
  logic [7:0]  s_araddr     = 8'h00;
  logic [31:0] s_wdata      = 32'h0;
  logic [3:0]  s_wstrb      = 4'hF;
  logic [9:0]  sample_data  = 10'h000;
  logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid, conv_clk, sample_switch, irq;
  logic [1:0]  s_bresp, s_rresp, rsp;
  logic [31:0] s_rdata, rd;
  logic [4:0]  chan_sel;
  int          err_count = 0;
  int          checks    = 0;
  int          cyc       = 0;
  int          sw_cnt    = 0;
  int          k;

  asc_tb_row_t rows [9] = '{
    '{IDX_DLY, 32'hA5, 32'hA5, RESP_OKAY}, '{IDX_WIN_MODE, 32'hFF, 32'h07, RESP_OKAY},
    '{IDX_SAMP_LEN, 32'hFF, 32'h1F, RESP_OKAY}, '{IDX_CHAN, 32'hFF, 32'h1F, RESP_OKAY},
    '{IDX_EVT, 32'hFF, 32'h01, RESP_OKAY}, '{IDX_IRQ_EN, 32'hFF, 32'h03, RESP_OKAY},
    '{IDX_WIN_LO, 32'h12345678, 32'h5678, RESP_OKAY}, '{IDX_IRQ_FLAG, 32'hFF, 32'h00, RESP_OKAY},
    '{6'h07, 32'h55, 32'h00, RESP_SLVERR}};

  asc_tb_win_t wt [10] = '{
    '{3'h1, 10'h0FF, 1'b1}, '{3'h1, 10'h100, 1'b0}, '{3'h2, 10'h201, 1'b1}, '{3'h2, 10'h200, 1'b0},
    '{3'h3, 10'h101, 1'b1}, '{3'h3, 10'h100, 1'b0}, '{3'h4, 10'h0FF, 1'b1}, '{3'h4, 10'h150, 1'b0},
    '{3'h0, 10'h0FF, 1'b0}, '{3'h5, 10'h0FF, 1'b0}};

  asc_top dut_u (
    .aclk, .aresetn, .s_awvalid, .s_awready, .s_awaddr, .s_wvalid, .s_wready, .s_wdata, .s_wstrb,
    .s_bvalid, .s_bready, .s_bresp, .s_arvalid, .s_arready, .s_araddr, .s_rvalid, .s_rready,
    .s_rdata, .s_rresp, .start_event, .wake_measure, .sample_data, .conv_clk, .sample_switch,
    .chan_sel, .irq
  );

  always #10 aclk = ~aclk;

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (sample_switch === 1'b1) sw_cnt <= sw_cnt + 1;
    if (cyc == 40000) begin
      err_count = err_count + 1;
      summarize();
    end
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic summarize();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [5:0] idx, input logic [31:0] d);
    s_awaddr  <= {idx, 2'b00};
    s_wdata   <= d;
    s_awvalid <= 1'b1;
    s_wvalid  <= 1'b1;
    s_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_awready === 1'b1) s_awvalid <= 1'b0;
      if (s_wready === 1'b1) s_wvalid <= 1'b0;
    end while (s_bvalid !== 1'b1);
    rsp = s_bresp;
    s_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rdr(input logic [5:0] idx);
    s_araddr  <= {idx, 2'b00};
    s_arvalid <= 1'b1;
    s_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_arready === 1'b1) s_arvalid <= 1'b0;
    end while (s_rvalid !== 1'b1);
    rd = s_rdata;
    rsp = s_rresp;
    s_rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic wait_irq();
    k = 0;
    while (irq !== 1'b1 && k < 2000) begin
      @(posedge aclk);
      k++;
    end
    chk("irq", irq, 1'b1);
  endtask

  // how: 0 command, 1 event, 2 wake; t = cycles to sampling, len = switch-closed cycles
  task automatic conv(input int how, output int t, output int len);
    int s0;
    // clear stale flags so the irq wait sees this conversion end
    rdr(IDX_RESULT);
    s0 = sw_cnt;
    if (how == 0) wr(IDX_CMD, 32'h1);
    else begin
      start_event  <= (how == 1);
      wake_measure <= (how == 2);
      @(posedge aclk);
      start_event  <= 1'b0;
      wake_measure <= 1'b0;
    end
    t = 0;
    while (sample_switch !== 1'b1 && t < 2000) begin
      @(posedge aclk);
      t++;
    end
    wait_irq();
    len = sw_cnt - s0;
  endtask

  task automatic rise(output int n);
    logic p;
    n = 0;
    do begin
      p = conv_clk;
      @(posedge aclk);
      n++;
    end while (!(p === 1'b0 && conv_clk === 1'b1) && n < 1000);
  endtask

  // cycles of one open-switch stretch between two samples
  task automatic low_run(output int n);
    n = 0;
    while (sample_switch !== 1'b1 && n < 2000) begin
      @(posedge aclk);
      n++;
    end
    while (sample_switch !== 1'b0 && n < 2000) begin
      @(posedge aclk);
      n++;
    end
    n = 0;
    while (sample_switch !== 1'b1 && n < 2000) begin
      @(posedge aclk);
      n++;
    end
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    int t;
    int len;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (rows[i]) begin
      rdr(rows[i].idx);
      chk("reset", rd, 32'h0);
    end
    foreach (rows[i]) begin
      wr(rows[i].idx, rows[i].wd);
      chk("bresp", rsp, rows[i].rs);
      rdr(rows[i].idx);
      chk("rdata", rd, rows[i].ex);
      chk("rresp", rsp, rows[i].rs);
    end
    wr(IDX_CHAN, 32'h0);
    wr(IDX_SAMP_LEN, 32'h0);
    wr(IDX_EVT, 32'h0);
    wr(IDX_DLY, 32'h0);
    wr(IDX_WIN_LO, 32'h0100);
    wr(IDX_WIN_HI, 32'h0200);
    wr(IDX_CTRL_A, 32'h1);
    foreach (wt[i]) begin
      wr(IDX_WIN_MODE, {29'h0, wt[i].m});
      sample_data <= wt[i].s;
      conv(0, t, len);
      rdr(IDX_IRQ_FLAG);
      chk("flags", rd, {30'h0, wt[i].e, 1'b1});
      rdr(IDX_RESULT);
      chk("result", rd, {22'h0, wt[i].s});
      rdr(IDX_IRQ_FLAG);
      chk("flags_read_clr", rd, 32'h0);
      chk("irq_low", irq, 1'b0);
    end
    // ****************************************
    // busy, abort, event, masking
    // ****************************************
    wr(IDX_CMD, 32'h1);
    rdr(IDX_CMD);
    chk("busy", rd, 32'h1);
    wait_irq();
    rdr(IDX_CMD);
    chk("done", rd, 32'h0);
    rdr(IDX_RESULT);
    wr(IDX_CMD, 32'h1);
    wr(IDX_CMD, 32'h0);
    repeat (100) @(posedge aclk);
    rdr(IDX_IRQ_FLAG);
    chk("abort", rd, 32'h0);
    wr(IDX_EVT, 32'h1);
    conv(1, t, len);
    rdr(IDX_IRQ_FLAG);
    chk("event", rd, 32'h1);
    wr(IDX_IRQ_EN, 32'h2);
    chk("mask", irq, 1'b0);
    wr(IDX_IRQ_FLAG, 32'h0);
    rdr(IDX_IRQ_FLAG);
    chk("w0", rd, 32'h1);
    wr(IDX_IRQ_FLAG, 32'h1);
    rdr(IDX_IRQ_FLAG);
    chk("w1c", rd, 32'h0);
    wr(IDX_IRQ_EN, 32'h3);
    // ****************************************
    // timing, delays, channel
    // ****************************************
    wr(IDX_SAMP_LEN, 32'h3);
    conv(0, t, len);
    chk("samp_len", (len >= 9 && len <= 10), 1'b1);
    rdr(IDX_RESULT);
    wr(IDX_DLY, 32'h20);
    wr(IDX_CTRL_A, 32'h0);
    wr(IDX_CTRL_A, 32'h1);
    conv(0, t, len);
    chk("init", (t >= 26 && t <= 38), 1'b1);
    rdr(IDX_RESULT);
    conv(2, t, len);
    chk("wake", (t >= 26 && t <= 38), 1'b1);
    rdr(IDX_RESULT);
    wr(IDX_DLY, 32'h1F);
    conv(0, t, len);
    rdr(IDX_DLY);
    chk("wrap", rd, 32'h10);
    conv(0, t, len);
    rdr(IDX_DLY);
    chk("incr", rd, 32'h11);
    rdr(IDX_RESULT);
    wr(IDX_CHAN, 32'h1E);
    wr(IDX_CMD, 32'h1);
    wr(IDX_CHAN, 32'h02);
    chk("chan_hold", chan_sel, 5'h1E);
    wait_irq();
    conv(0, t, len);
    chk("chan_new", chan_sel, 5'h02);
    wr(IDX_CHAN, 32'h05);
    conv(0, t, len);
    chk("chan_rsvd", chan_sel, CHAN_GND);
    // free run: switch stays open through conversion and gap
    wr(IDX_DLY, 32'h04);
    wr(IDX_CTRL_A, 32'h3);
    wr(IDX_CMD, 32'h1);
    low_run(t);
    chk("gap_open", t, (int'(CONV_TICKS) + 4) * 2);
    wr(IDX_CMD, 32'h0);
    rdr(IDX_CMD);
    chk("fr_stop", rd, 32'h0);
    for (int c = 0; c < 8; c++) begin
      wr(IDX_CTRL_C, c);
      rise(t);
      rise(t);
      rise(t);
      chk("div", t, 2 << c);
    end
    summarize();
  end
endmodule
